// ==== verilog/pile_exec.sv ====
`timescale 1ns/1ps
// Function
// (RQ1) The opcode 1001100011 is decoded as the one-word port-three input.
// (RQ2) Port-three input copies the two port pins into accumulator bits 1:0.
// (RQ3) Port-three input clears accumulator bits 3:2.
// (RQ4) Index increment adds one to Y mod 16 and skips the next word on 0.
// (RQ5) Accumulator immediate load writes its 4-bit field into A.
// (RQ6) In a run of accumulator loads only the first one executes.
// (RQ7) Row/column load holds prefix 11, then X field, then Y field.
// (RQ8) Row/column load writes the upper field to X and the lower to Y.
// (RQ9) In a run of row/column loads only the first one executes.
// (RQ10) Each instruction is one word, one cycle, and leaves carry alone.
// (RQ11) A skipped word uses its cycle but changes no register or flag. Code: it still clears skip_q and is recorded in last_op_q.
module pile_exec
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [pile_pkg::INSTR_W-1:0] instr_i,
  input wire logic [1:0] two_bit_port_three_i,
  input wire logic carry_flag_i,
  output logic [pile_pkg::DATA_W-1:0] acc_o,
  output logic [pile_pkg::DATA_W-1:0] reg_x_o,
  output logic [pile_pkg::DATA_W-1:0] reg_y_o,
  output logic carry_flag_o,
  output logic skip_o
);
  import pile_pkg::*;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Fixed opcodes are matched before the masked groups
  function automatic pile_op_t decode(input logic [INSTR_W-1:0] w);
    pile_op_t op;
    op = PILE_OP_NONE;
    if (w == OPC_PORT3_IN)
      op = PILE_OP_PORT3_IN; // [RQ1]
    else if (w == OPC_INCR_IDX)
      op = PILE_OP_INCR_IDX;
    else if ((w & MSK_LOAD_ACC) == OPC_LOAD_ACC)
      op = PILE_OP_LOAD_ACC;
    else if ((w & MSK_LOAD_RC) == OPC_LOAD_RC)
      op = PILE_OP_LOAD_RC; // [RQ7]
    return op;
  endfunction

  // Port pins are asynchronous: two flops before use
  logic [PORT3_W-1:0] p3_meta_q, p3_sync_q;
  always_ff @(posedge mclk_i)
  begin
    p3_meta_q <= two_bit_port_three_i;
    p3_sync_q <= p3_meta_q;
  end

  // ----------------------------------------
  // Execute
  // ----------------------------------------
  pile_op_t op, last_op_q, last_op_d;
  logic [DATA_W-1:0] acc_q, acc_d, x_q, x_d, y_q, y_d, y_inc;
  logic skip_q, skip_d;

  assign op = decode(instr_i);
  assign y_inc = y_q + ONE_NIBBLE;

  always_comb
  begin
    acc_d = acc_q;
    x_d = x_q;
    y_d = y_q;
    skip_d = skip_q;
    last_op_d = last_op_q;
    if (instr_valid_i)
    begin
      // Idle cycles leave the history alone, so a bubble does not end a run
      last_op_d = op;
      skip_d = 1'h0;
      // A skipped word still uses its slot; A, X and Y are left untouched
      if (!skip_q) // [RQ11]
      begin
        case (op)
          PILE_OP_PORT3_IN:
            acc_d = {ZERO_HI, p3_sync_q}; // [RQ2] [RQ3]
          PILE_OP_INCR_IDX:
          begin
            y_d = y_inc; // [RQ4]
            skip_d = (y_inc == RST_NIBBLE); // [RQ4]
          end
          PILE_OP_LOAD_ACC:
            if (last_op_q != PILE_OP_LOAD_ACC) // [RQ6]
              acc_d = instr_i[IMM_LO_LSB +: DATA_W]; // [RQ5]
          PILE_OP_LOAD_RC:
            if (last_op_q != PILE_OP_LOAD_RC) // [RQ9]
            begin
              x_d = instr_i[IMM_HI_LSB +: DATA_W]; // [RQ8]
              y_d = instr_i[IMM_LO_LSB +: DATA_W]; // [RQ8]
            end
          default:
            acc_d = acc_q;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    // Only the state registers reset; the pin flops flush within two cycles
    if (!rst_n_i)
    begin
      acc_q <= RST_NIBBLE;
      x_q <= RST_NIBBLE;
      y_q <= RST_NIBBLE;
      skip_q <= 1'h0;
      last_op_q <= PILE_OP_NONE;
    end
    else
    begin
      acc_q <= acc_d;
      x_q <= x_d;
      y_q <= y_d;
      skip_q <= skip_d;
      last_op_q <= last_op_d;
    end
  end

  assign acc_o = acc_q;
  assign reg_x_o = x_q;
  assign reg_y_o = y_q;
  // Carry is outside these instructions; pass it through unchanged
  assign carry_flag_o = carry_flag_i; // [RQ10]
  assign skip_o = skip_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // Consequents look one cycle on: every word completes in one cycle
  a_port3_low_bits: assert property ( // [RQ2]
    instr_valid_i && !skip_q && op == PILE_OP_PORT3_IN
    |=> acc_q[PORT3_W-1:0] == $past(p3_sync_q))
    else $error("port three bits not loaded");
  a_port3_high_zero: assert property ( // [RQ3]
    instr_valid_i && !skip_q && instr_i == OPC_PORT3_IN
    |=> acc_q[DATA_W-1:PORT3_W] == ZERO_HI)
    else $error("accumulator high bits not cleared");
  a_incr_wraps: assert property ( // [RQ4]
    instr_valid_i && !skip_q && op == PILE_OP_INCR_IDX
    |=> y_q == $past(y_q) + ONE_NIBBLE && skip_q == (y_q == RST_NIBBLE))
    else $error("index increment or skip wrong");
  a_acc_load_first: assert property ( // [RQ5]
    instr_valid_i && !skip_q && op == PILE_OP_LOAD_ACC
    && last_op_q != PILE_OP_LOAD_ACC |=> acc_q == $past(instr_i[3:0]))
    else $error("accumulator immediate not loaded");
  a_acc_run_held: assert property ( // [RQ6]
    instr_valid_i && op == PILE_OP_LOAD_ACC
    && last_op_q == PILE_OP_LOAD_ACC |=> $stable(acc_q))
    else $error("repeated accumulator load executed");
  a_rc_load_first: assert property ( // [RQ8]
    instr_valid_i && !skip_q && op == PILE_OP_LOAD_RC
    && last_op_q != PILE_OP_LOAD_RC
    |=> {x_q, y_q} == $past(instr_i[IMM_LO_LSB +: 2*DATA_W]))
    else $error("row/column immediate not loaded");
  a_rc_run_held: assert property ( // [RQ9]
    instr_valid_i && op == PILE_OP_LOAD_RC
    && last_op_q == PILE_OP_LOAD_RC |=> $stable(x_q) && $stable(y_q))
    else $error("repeated row/column load executed");
  a_skip_no_change: assert property ( // [RQ11]
    instr_valid_i && skip_q
    |=> $stable(acc_q) && $stable(x_q) && $stable(y_q) && !skip_q)
    else $error("skipped word changed state");
  // Carry has no path through this block, so it can only mirror the core
  a_carry_kept: assert property ( // [RQ10]
    carry_flag_o == carry_flag_i)
    else $error("carry altered");

  // Nothing moves on a bubble; every change is tied to one fetched word
  a_idle_holds: assert property ( // [RQ10]
    !instr_valid_i |=> $stable(acc_q) && $stable(x_q) && $stable(y_q)
    && $stable(skip_q) && $stable(last_op_q))
    else $error("state changed without a fetched word");
  a_history_tracks: assert property ( // [RQ6]
    instr_valid_i |=> last_op_q == $past(op))
    else $error("run history not updated");
  a_skip_only_incr: assert property ( // [RQ4]
    instr_valid_i && (skip_q || op != PILE_OP_INCR_IDX) |=> !skip_q)
    else $error("skip raised by a non-increment word");

  a_port3_single_word: assert property ( // [RQ1]
    instr_valid_i && !skip_q && op == PILE_OP_PORT3_IN
    |=> $stable(x_q) && $stable(y_q))
    else $error("port three input touched the index registers");
  a_incr_keeps_acc: assert property ( // [RQ4]
    instr_valid_i && !skip_q && op == PILE_OP_INCR_IDX
    |=> $stable(acc_q) && $stable(x_q))
    else $error("index increment touched other registers");
  a_acc_keeps_index: assert property ( // [RQ5]
    instr_valid_i && !skip_q && op == PILE_OP_LOAD_ACC
    |=> $stable(x_q) && $stable(y_q))
    else $error("accumulator load touched the index registers");
  a_rc_keeps_acc: assert property ( // [RQ8]
    instr_valid_i && !skip_q && op == PILE_OP_LOAD_RC
    |=> $stable(acc_q))
    else $error("row/column load touched the accumulator");
  a_other_word_inert: assert property ( // [RQ1]
    instr_valid_i && !skip_q && op == PILE_OP_NONE
    |=> $stable(acc_q) && $stable(x_q) && $stable(y_q))
    else $error("undecoded word changed state");

  // ----------------------------------------
  // Covers
  // ----------------------------------------
  c_port3: cover property (instr_valid_i && op == PILE_OP_PORT3_IN);
  c_rc_load: cover property (instr_valid_i && !skip_q
    && op == PILE_OP_LOAD_RC && last_op_q != PILE_OP_LOAD_RC);
  c_incr_skip: cover property (skip_q && instr_valid_i);
  c_acc_run: cover property (instr_valid_i && op == PILE_OP_LOAD_ACC
    && last_op_q == PILE_OP_LOAD_ACC);
  c_rc_run: cover property (instr_valid_i && op == PILE_OP_LOAD_RC
    && last_op_q == PILE_OP_LOAD_RC);
endmodule

// ==== shared/pile_pkg.sv ====
package pile_pkg;
  localparam int unsigned DATA_W = 4;
  localparam int unsigned INSTR_W = 10;
  // Opcodes and masks for the four decoded instructions
  localparam logic [9:0] OPC_PORT3_IN = 10'h263;
  localparam logic [9:0] OPC_INCR_IDX = 10'h013;
  localparam logic [9:0] MSK_LOAD_ACC = 10'h3f0;
  localparam logic [9:0] OPC_LOAD_ACC = 10'h070;
  localparam logic [9:0] MSK_LOAD_RC = 10'h300;
  localparam logic [9:0] OPC_LOAD_RC = 10'h300;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [3:0] ONE_NIBBLE = 4'h1;
  localparam logic [1:0] ZERO_HI = 2'h0;
  // Immediate field positions and port width
  localparam int unsigned IMM_LO_LSB = 0;
  localparam int unsigned IMM_HI_LSB = 4;
  localparam int unsigned PORT3_W = 2;
  typedef enum logic [2:0] {
    PILE_OP_NONE,
    PILE_OP_PORT3_IN,
    PILE_OP_INCR_IDX,
    PILE_OP_LOAD_ACC,
    PILE_OP_LOAD_RC
  } pile_op_t;
endpackage

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  import pile_pkg::*;
  logic mclk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic instr_valid_i = 1'h0;
  logic [INSTR_W-1:0] instr_i = '0;
  logic [1:0] pins = 2'h0;
  logic cy = 1'h0;
  logic [DATA_W-1:0] acc_o, reg_x_o, reg_y_o;
  logic carry_flag_o, skip_o;
  int fails = 0;
  int comparisons = 0;
  pile_exec dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .two_bit_port_three_i(pins), .carry_flag_i(cy), .acc_o(acc_o),
    .reg_x_o(reg_x_o), .reg_y_o(reg_y_o), .carry_flag_o(carry_flag_o),
    .skip_o(skip_o));
  initial
  begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One word per call; the idle cycle after it keeps runs intact
  task automatic exec(input logic [9:0] w);
    @(posedge mclk_i);
    #2 instr_i = w;
    instr_valid_i = 1'h1;
    @(posedge mclk_i);
    #2 instr_valid_i = 1'h0;
  endtask
  task automatic finish_test;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_port3;
    exec(10'h000);
    exec(10'h07f);
    pins = 2'h2;
    repeat (3) @(posedge mclk_i);
    #2 exec(10'h263);
    chk(acc_o, 4'h2);
    pins = 2'h1;
    cy = 1'h1;
    repeat (3) @(posedge mclk_i);
    #2 exec(10'h263);
    chk(acc_o, 4'h1);
    chk({3'h0, carry_flag_o}, 4'h1);
    cy = 1'h0;
    #1 chk({3'h0, carry_flag_o}, 4'h0);
  endtask
  task automatic t_incr;
    exec(10'h000);
    exec(10'h30f);
    exec(10'h013);
    chk(reg_y_o, 4'h0);
    chk({3'h0, skip_o}, 4'h1);
    exec(10'h075);
    chk(acc_o, 4'h1);
    chk({3'h0, skip_o}, 4'h0);
    exec(10'h013);
    chk(reg_y_o, 4'h1);
    chk({3'h0, skip_o}, 4'h0);
    exec(10'h074);
    chk(acc_o, 4'h4);
  endtask
  task automatic t_load_acc;
    exec(10'h000);
    exec(10'h07a);
    exec(10'h075);
    chk(acc_o, 4'ha);
    exec(10'h000);
    exec(10'h07f);
    chk(acc_o, 4'hf);
  endtask
  task automatic t_load_rc;
    exec(10'h000);
    exec(10'h35a);
    exec(10'h312);
    chk(reg_x_o, 4'h5);
    chk(reg_y_o, 4'ha);
    exec(10'h000);
    exec(10'h3ef);
    exec(10'h013);
    exec(10'h3c3);
    chk(reg_x_o, 4'he);
    chk(reg_y_o, 4'h0);
  endtask
  initial
  begin
    repeat (12) @(posedge mclk_i);
    #2 rst_n_i = 1'h1;
    t_port3();
    t_incr();
    t_load_acc();
    t_load_rc();
    finish_test();
  end
  initial
  begin
    #(25 * 2000);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
endmodule
